// *** hw/dlsb_log_builder.sv ***
`timescale 1ns/100ps
// Behaviour
// RULE1: entry offset n reserved; n+1..n+7 hold completion register image.
// RULE2: for a hardware reset, n+1..n+7 carry a vendor value instead.
// RULE3: offsets n+8..n+26 of an error entry are vendor extended info.
// RULE4: n+27 low nibble holds device state when command accepted; hardware-reset entries store DEV_STATE_IN at the reset instead.
// RULE5: upper nibble of the state byte is a vendor value.
// RULE6: n+28/n+29 hold lifetime hours at completion, low byte first.
// RULE7: keep a lifetime count of device-caused errors in the error sector.
// RULE8: errors from faulty host requests never bump the count.
// RULE9: the device error count saturates at its maximum.
// RULE10: byte 511 is the negated mod-256 sum of bytes 0..510.
// RULE11: self-test sector bytes 0-1 carry revision 0001h.
// RULE12: 24-byte descriptors from byte 2; index at 508; 506-507 and 509-510 filler.
// RULE13: descriptors wrap: the 22nd result overwrites the first.
// RULE14: unused descriptors read as all zero bytes.
// RULE15: index is 0 when empty, then 1..21, wrapping back to 1.
// RULE16: descriptor: sector, status, hours, checkpoint, failing LBA, vendor.
// RULE17: descriptor sector number is captured when the test is issued.
// RULE18: hours, status and checkpoint are captured at test completion.
// RULE19: failing LBA is the first uncorrectable sector, else undefined.
// RULE20: error log keeps last five entries circularly, unused zero filled.
// RULE21: checksum accumulates during streaming and goes out as last byte.
// RULE22: index and descriptor are written on the same clock edge.
module dlsb_log_builder
(
	input wire logic CORE_CLK_IN,
	input wire logic RESETN_IN,
	input wire logic CMD_ACCEPT_IN,
	input wire logic [3:0] DEV_STATE_IN,
	input wire logic ERR_EVENT_IN,
	input wire logic ERR_HOST_FAULT_IN,
	input wire logic ERR_HW_RESET_IN,
	input wire logic [55:0] ERR_REGS_IN,
	input wire logic [15:0] LIFE_HOURS_IN,
	input wire logic ST_ISSUE_IN,
	input wire logic [7:0] ST_SECTOR_IN,
	input wire logic ST_DONE_IN,
	input wire logic [7:0] ST_STATUS_IN,
	input wire logic [7:0] ST_CHECKPOINT_IN,
	input wire logic [31:0] ST_FAIL_LBA_IN,
	input wire logic RD_REQ_IN,
	input wire logic RD_SEL_IN,
	output logic RD_BUSY_OUT,
	output logic RD_VALID_OUT,
	output logic [7:0] RD_DATA_OUT,
	output logic RD_LAST_OUT
);
	import dlsb_pkg::*;

	typedef enum logic {DLSB_IDLE, DLSB_STREAM} dlsb_state_t;

	dlsb_state_t state_reg;
	logic sel_reg;
	logic busy_reg;
	logic [8:0] pos_reg;
	logic [4:0] ent_reg;
	logic [6:0] off_reg;
	logic [7:0] byte_val;
	logic start;

	// error log storage
	logic [55:0] err_regs_mem [ERR_ENTRIES];
	logic [7:0] err_state_mem [ERR_ENTRIES];
	logic [15:0] err_hours_mem [ERR_ENTRIES];
	logic [ERR_ENTRIES-1:0] err_used_reg;
	logic [2:0] err_idx_reg;
	logic [2:0] err_idx_next;
	logic [15:0] err_cnt_reg;
	logic [3:0] acc_state_reg;
	logic err_log;

	// self-test log storage
	logic [7:0] st_sec_mem [ST_ENTRIES];
	logic [7:0] st_stat_mem [ST_ENTRIES];
	logic [15:0] st_hours_mem [ST_ENTRIES];
	logic [7:0] st_ckpt_mem [ST_ENTRIES];
	logic [31:0] st_lba_mem [ST_ENTRIES];
	logic [ST_ENTRIES-1:0] st_used_reg;
	logic [4:0] st_idx_reg;
	logic [4:0] st_idx_next;
	logic [7:0] st_pend_sec_reg;

	dlsb_byte_if link ();

	////////////////////////////////////////////////////////////////////////
	// device state latched at command acceptance
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (!RESETN_IN)
			acc_state_reg <= STATE_UNKNOWN;
		else if (CMD_ACCEPT_IN)
			acc_state_reg <= DEV_STATE_IN; // RULE4
	end

	// host-caused errors are kept out of the log altogether
	assign err_log = ERR_EVENT_IN & ~ERR_HOST_FAULT_IN;
	assign err_idx_next = (err_idx_reg == ERR_IDX_MAX) ? 3'h1 : err_idx_reg + 3'h1;

	// error entry write; index and entry move together
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (!RESETN_IN)
		begin
			err_idx_reg <= 3'h0;
			err_used_reg <= '0;
		end
		else if (err_log)
		begin
			err_idx_reg <= err_idx_next; // RULE20
			err_used_reg[err_idx_next - 3'h1] <= 1'b1;
		end
	end

	// entry contents are not reset: the used bits hide stale data
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (err_log)
		begin
			if (ERR_HW_RESET_IN)
				err_regs_mem[err_idx_next - 3'h1] <= {7{HWRST_VENDOR_BYTE}}; // RULE2
			else
				err_regs_mem[err_idx_next - 3'h1] <= ERR_REGS_IN; // RULE1
			err_state_mem[err_idx_next - 3'h1] <= {STATE_VENDOR_NIBBLE, // RULE5
				ERR_HW_RESET_IN ? DEV_STATE_IN : acc_state_reg}; // RULE4
			err_hours_mem[err_idx_next - 3'h1] <= LIFE_HOURS_IN; // RULE6
		end
	end

	// lifetime count, resets count as events but not as device errors
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (!RESETN_IN)
			err_cnt_reg <= 16'h0000;
		else if (err_log && !ERR_HW_RESET_IN && err_cnt_reg != ERR_CNT_MAX) // RULE8 RULE9
			err_cnt_reg <= err_cnt_reg + 16'h0001; // RULE7
	end

	////////////////////////////////////////////////////////////////////////
	// sector number captured when the test subcommand is issued
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (!RESETN_IN)
			st_pend_sec_reg <= 8'h00;
		else if (ST_ISSUE_IN)
			st_pend_sec_reg <= ST_SECTOR_IN; // RULE17
	end

	assign st_idx_next = (st_idx_reg == ST_IDX_MAX) ? 5'h01 : st_idx_reg + 5'h01; // RULE13

	// index and used bit change on the same edge as the descriptor
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (!RESETN_IN)
		begin
			st_idx_reg <= 5'h00; // RULE15
			st_used_reg <= '0; // RULE14
		end
		else if (ST_DONE_IN)
		begin
			st_idx_reg <= st_idx_next; // RULE15 RULE22
			st_used_reg[st_idx_next - 5'h01] <= 1'b1;
		end
	end

	// completion-time fields; lba is whatever the test reports
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (ST_DONE_IN)
		begin
			st_sec_mem[st_idx_next - 5'h01] <= st_pend_sec_reg; // RULE16 RULE22
			st_stat_mem[st_idx_next - 5'h01] <= ST_STATUS_IN; // RULE18
			st_hours_mem[st_idx_next - 5'h01] <= LIFE_HOURS_IN; // RULE18
			st_ckpt_mem[st_idx_next - 5'h01] <= ST_CHECKPOINT_IN; // RULE18
			st_lba_mem[st_idx_next - 5'h01] <= ST_FAIL_LBA_IN; // RULE19
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read sequencer: one byte a cycle, no stall, requests while busy dropped
	assign start = (state_reg == DLSB_IDLE) && RD_REQ_IN;

	always_ff @(posedge CORE_CLK_IN)
	begin
		if (!RESETN_IN)
		begin
			state_reg <= DLSB_IDLE;
			busy_reg <= 1'b0;
			sel_reg <= LOG_SEL_ERROR;
		end
		else
		begin
			unique case (state_reg)
				DLSB_IDLE:
				begin
					if (RD_REQ_IN)
					begin
						state_reg <= DLSB_STREAM;
						busy_reg <= 1'b1;
						sel_reg <= RD_SEL_IN;
					end
				end
				DLSB_STREAM:
				begin
					if (pos_reg == POS_LAST)
					begin
						state_reg <= DLSB_IDLE;
						busy_reg <= 1'b0;
					end
				end
			endcase
		end
	end

	// byte position plus entry/offset counters, avoiding a divider
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (!RESETN_IN || start)
		begin
			pos_reg <= 9'h000;
			ent_reg <= 5'h00;
			off_reg <= 7'h00;
		end
		else if (state_reg == DLSB_STREAM)
		begin
			pos_reg <= pos_reg + 9'h001;
			if (pos_reg >= POS_FIRST_ENTRY)
			begin
				if (off_reg == ((sel_reg == LOG_SEL_ERROR) ? ERR_ENT_LAST_OFF : ST_ENT_LAST_OFF))
				begin
					off_reg <= 7'h00;
					ent_reg <= ent_reg + 5'h01;
				end
				else
					off_reg <= off_reg + 7'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sector content at the current position; anything unnamed reads zero
	always_comb
	begin
		byte_val = 8'h00;
		if (sel_reg == LOG_SEL_ERROR)
		begin
			if (pos_reg == POS_HDR_LO)
				byte_val = ERR_LOG_VERSION;
			else if (pos_reg == POS_HDR_HI)
				byte_val = {5'h00, err_idx_reg};
			else if (pos_reg < ERR_CNT_LO_POS)
			begin
				if (err_used_reg[ent_reg[2:0]]) // RULE20
				begin
					// offsets below the register image and n+8..n+26 stay zero
					if (off_reg >= ED_REG_FIRST && off_reg <= ED_REG_LAST) // RULE1 RULE3
						byte_val = err_regs_mem[ent_reg[2:0]][{3'(off_reg - ED_REG_FIRST), 3'h0} +: 8];
					else if (off_reg == ED_STATE)
						byte_val = err_state_mem[ent_reg[2:0]]; // RULE4
					else if (off_reg == ED_HOURS_LO)
						byte_val = err_hours_mem[ent_reg[2:0]][7:0]; // RULE6
					else if (off_reg == ED_HOURS_HI)
						byte_val = err_hours_mem[ent_reg[2:0]][15:8]; // RULE6
				end
			end
			else if (pos_reg == ERR_CNT_LO_POS)
				byte_val = err_cnt_reg[7:0]; // RULE7
			else if (pos_reg == ERR_CNT_HI_POS)
				byte_val = err_cnt_reg[15:8]; // RULE7
		end
		else
		begin
			if (pos_reg == POS_HDR_LO)
				byte_val = ST_REVISION[7:0]; // RULE11
			else if (pos_reg == POS_HDR_HI)
				byte_val = ST_REVISION[15:8]; // RULE11
			else if (pos_reg < ST_DESC_END_POS)
			begin
				if (st_used_reg[ent_reg]) // RULE14
				begin
					unique case (off_reg)
						DS_SECTOR: byte_val = st_sec_mem[ent_reg]; // RULE16
						DS_STATUS: byte_val = st_stat_mem[ent_reg];
						DS_HOURS_LO: byte_val = st_hours_mem[ent_reg][7:0];
						DS_HOURS_HI: byte_val = st_hours_mem[ent_reg][15:8];
						DS_CKPT: byte_val = st_ckpt_mem[ent_reg];
						DS_LBA_B0: byte_val = st_lba_mem[ent_reg][7:0];
						DS_LBA_B1: byte_val = st_lba_mem[ent_reg][15:8];
						DS_LBA_B2: byte_val = st_lba_mem[ent_reg][23:16];
						DS_LBA_B3: byte_val = st_lba_mem[ent_reg][31:24];
						default: byte_val = 8'h00;
					endcase
				end
			end
			else if (pos_reg == ST_INDEX_POS)
				byte_val = {3'h0, st_idx_reg}; // RULE12 RULE15
		end
	end

	assign link.in_valid = (state_reg == DLSB_STREAM);
	assign link.in_data = byte_val;
	assign link.in_last = (pos_reg == POS_LAST); // RULE10 RULE21

	// checksum stage; its outputs are flops and feed the pins directly
	dlsb_sector_tx u_tx
	(
		.clk_in(CORE_CLK_IN),
		.resetn_in(RESETN_IN),
		.bus(link.tx)
	);

	assign RD_BUSY_OUT = busy_reg;
	assign RD_VALID_OUT = link.out_valid;
	assign RD_DATA_OUT = link.out_data;
	assign RD_LAST_OUT = link.out_last;

	////////////////////////////////////////////////////////////////////////
	property p_cnt_inc;
		@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
		(err_log && !ERR_HW_RESET_IN && err_cnt_reg != ERR_CNT_MAX)
			|=> (err_cnt_reg == $past(err_cnt_reg) + 16'h0001);
	endproperty
	a_cnt_inc: assert property (p_cnt_inc) // RULE7
		else $error("device error count did not advance");

	property p_cnt_host;
		@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
		(ERR_EVENT_IN && ERR_HOST_FAULT_IN) |=> $stable(err_cnt_reg) && $stable(err_idx_reg);
	endproperty
	a_cnt_host: assert property (p_cnt_host) // RULE8
		else $error("host fault changed the error log");

	property p_cnt_sat;
		@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
		(err_cnt_reg == ERR_CNT_MAX) |=> (err_cnt_reg == ERR_CNT_MAX);
	endproperty
	a_cnt_sat: assert property (p_cnt_sat) // RULE9
		else $error("device error count left its maximum");

	property p_err_wrap;
		@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
		(err_log && err_idx_reg == ERR_IDX_MAX) |=> (err_idx_reg == 3'h1);
	endproperty
	a_err_wrap: assert property (p_err_wrap) // RULE20
		else $error("error index did not wrap to one");

	property p_st_adv;
		@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
		(ST_DONE_IN && st_idx_reg != ST_IDX_MAX)
			|=> (st_idx_reg == $past(st_idx_reg) + 5'h01) && st_used_reg[st_idx_reg - 5'h01];
	endproperty
	a_st_adv: assert property (p_st_adv) // RULE22
		else $error("self-test index and entry out of step");

	property p_st_wrap;
		@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
		(ST_DONE_IN && st_idx_reg == ST_IDX_MAX) |=> (st_idx_reg == 5'h01);
	endproperty
	a_st_wrap: assert property (p_st_wrap) // RULE15
		else $error("self-test index did not wrap to one");

	property p_st_sector;
		@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
		(ST_DONE_IN && !ST_ISSUE_IN) |=> (st_sec_mem[st_idx_reg - 5'h01] == $past(st_pend_sec_reg));
	endproperty
	a_st_sector: assert property (p_st_sector) // RULE17
		else $error("descriptor sector number not from issue time");

	property p_rev_word;
		@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
		(link.in_valid && sel_reg == LOG_SEL_SELFTEST && pos_reg == POS_HDR_LO)
			|-> (byte_val == ST_REVISION[7:0]) ##1 (byte_val == ST_REVISION[15:8]);
	endproperty
	a_rev_word: assert property (p_rev_word) // RULE11
		else $error("self-test revision word wrong");

	property p_st_unused;
		@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
		(link.in_valid && sel_reg == LOG_SEL_SELFTEST && pos_reg >= POS_FIRST_ENTRY
			&& pos_reg < ST_DESC_END_POS && !st_used_reg[ent_reg]) |-> (byte_val == 8'h00);
	endproperty
	a_st_unused: assert property (p_st_unused) // RULE14
		else $error("unused descriptor not zero");

	property p_stream_len;
		@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
		start |-> ##[513:513] RD_LAST_OUT;
	endproperty
	a_stream_len: assert property (p_stream_len) // RULE21
		else $error("checksum byte not last of 512");
endmodule

// *** hw/dlsb_pkg.sv ***
package dlsb_pkg;
	// sector geometry, byte positions within a 512-byte log sector
	localparam int unsigned SECTOR_BYTES = 512;
	localparam logic [8:0] POS_LAST = 9'h1ff;
	localparam logic [8:0] POS_FIRST_ENTRY = 9'h002;
	// two header bytes ahead of the first entry of either sector
	localparam logic [8:0] POS_HDR_LO = 9'h000;
	localparam logic [8:0] POS_HDR_HI = 9'h001;
	// error log sector layout
	localparam logic [7:0] ERR_LOG_VERSION = 8'h01;
	localparam int unsigned ERR_ENTRIES = 5;
	localparam logic [2:0] ERR_IDX_MAX = 3'h5;
	localparam logic [6:0] ERR_ENT_LAST_OFF = 7'h59;
	localparam logic [8:0] ERR_CNT_LO_POS = 9'h1c4;
	localparam logic [8:0] ERR_CNT_HI_POS = 9'h1c5;
	// error data structure offsets inside one 90-byte entry
	localparam logic [6:0] ED_REG_FIRST = 7'h3d;
	localparam logic [6:0] ED_REG_LAST = 7'h43;
	localparam logic [6:0] ED_STATE = 7'h57;
	localparam logic [6:0] ED_HOURS_LO = 7'h58;
	localparam logic [6:0] ED_HOURS_HI = 7'h59;
	// device state codes held in the low nibble of the state byte
	localparam logic [3:0] STATE_UNKNOWN = 4'h0;
	localparam logic [3:0] STATE_SLEEP = 4'h1;
	localparam logic [3:0] STATE_STANDBY = 4'h2;
	localparam logic [3:0] STATE_ACTIVE = 4'h3;
	localparam logic [3:0] STATE_SELFTEST = 4'h4;
	// vendor part of the state byte and of the hw-reset register image
	localparam logic [3:0] STATE_VENDOR_NIBBLE = 4'h0;
	localparam logic [7:0] HWRST_VENDOR_BYTE = 8'h00;
	localparam logic [15:0] ERR_CNT_MAX = 16'hffff;
	// self-test log sector layout
	localparam logic [15:0] ST_REVISION = 16'h0001;
	localparam int unsigned ST_ENTRIES = 21;
	localparam logic [4:0] ST_IDX_MAX = 5'h15;
	localparam logic [6:0] ST_ENT_LAST_OFF = 7'h17;
	localparam logic [8:0] ST_DESC_END_POS = 9'h1fa;
	localparam logic [8:0] ST_INDEX_POS = 9'h1fc;
	// field offsets inside one 24-byte self-test descriptor, lba low byte first
	localparam logic [6:0] DS_SECTOR = 7'h00;
	localparam logic [6:0] DS_STATUS = 7'h01;
	localparam logic [6:0] DS_HOURS_LO = 7'h02;
	localparam logic [6:0] DS_HOURS_HI = 7'h03;
	localparam logic [6:0] DS_CKPT = 7'h04;
	localparam logic [6:0] DS_LBA_B0 = 7'h05;
	localparam logic [6:0] DS_LBA_B1 = 7'h06;
	localparam logic [6:0] DS_LBA_B2 = 7'h07;
	localparam logic [6:0] DS_LBA_B3 = 7'h08;
	// log selection on a read request
	localparam logic LOG_SEL_ERROR = 1'b0;
	localparam logic LOG_SEL_SELFTEST = 1'b1;
endpackage

// *** hw/dlsb_byte_if.sv ***
`timescale 1ns/100ps
// byte stream from the sector builder into the checksum stage and back out
interface dlsb_byte_if;
	logic in_valid;
	logic [7:0] in_data;
	logic in_last;
	logic out_valid;
	logic [7:0] out_data;
	logic out_last;
	modport builder (output in_valid, output in_data, output in_last,
		input out_valid, input out_data, input out_last);
	modport tx (input in_valid, input in_data, input in_last,
		output out_valid, output out_data, output out_last);
endinterface

// *** hw/dlsb_sector_tx.sv ***
`timescale 1ns/100ps
module dlsb_sector_tx
(
	input wire logic clk_in,
	input wire logic resetn_in,
	dlsb_byte_if.tx bus
);
	import dlsb_pkg::*;

	logic [7:0] sum_reg;
	logic [7:0] chk_sum_reg;
	logic [7:0] chk_total;

	////////////////////////////////////////////////////////////////////////
	// running sum of bytes 0..510, byte 511 replaced by its negation
	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
		begin
			sum_reg <= 8'h00;
			bus.out_valid <= 1'b0;
			bus.out_data <= 8'h00;
			bus.out_last <= 1'b0;
		end
		else
		begin
			bus.out_valid <= bus.in_valid;
			bus.out_last <= bus.in_valid & bus.in_last;
			if (bus.in_valid)
			begin
				if (bus.in_last)
				begin
					bus.out_data <= 8'h00 - sum_reg; // RULE10 RULE21
					sum_reg <= 8'h00;
				end
				else
				begin
					bus.out_data <= bus.in_data;
					sum_reg <= sum_reg + bus.in_data; // RULE21
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checker helper: sum of what actually left the stage
	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
			chk_sum_reg <= 8'h00;
		else if (bus.out_valid)
			chk_sum_reg <= bus.out_last ? 8'h00 : chk_total;
	end
	assign chk_total = chk_sum_reg + bus.out_data;

	property p_sector_sums_zero;
		@(posedge clk_in) disable iff (!resetn_in)
		(bus.out_valid && bus.out_last) |-> (chk_total == 8'h00);
	endproperty
	a_sector_sums_zero: assert property (p_sector_sums_zero) // RULE10
		else $error("sector bytes do not sum to zero");
endmodule

// *** dv/dlsb_host_reader.sv ***
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// host side: asks for one log sector and collects the streamed bytes
module dlsb_host_reader
(
	input wire logic clk_in,
	input wire logic busy_in,
	input wire logic valid_in,
	input wire logic [7:0] data_in,
	input wire logic last_in,
	output logic req_out,
	output logic sel_out
);
	logic [7:0] got [512];
	int got_n = 0;
	int last_pos = -1;
	initial
	begin
		req_out = 1'b0;
		sel_out = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// keep every byte; overruns only bump the count so a second frame shows up
	// sampled on the falling edge, where the registered outputs have settled
	always @(negedge clk_in)
	begin
		if (valid_in === 1'b1)
		begin
			if (got_n < 512)
				got[got_n] = data_in;
			if (last_in === 1'b1)
				last_pos = got_n;
			got_n = got_n + 1;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// request held two edges: the second lands while busy and must be ignored
	task automatic read_sector(input logic sel);
		got_n = 0;
		last_pos = -1;
		@(negedge clk_in);
		req_out = 1'b1;
		sel_out = sel;
		repeat (2) @(negedge clk_in);
		req_out = 1'b0;
		sel_out = ~sel; // released select shows the inverse, not the old value
		repeat (520) @(negedge clk_in);
	endtask
endmodule

// *** dv/dlsb_log_builder_tb_top.sv ***
`timescale 1ns/100ps
module dlsb_log_builder_tb_top;
	import dlsb_pkg::*;
	logic clk, rstn, cmd_acc, err_ev, err_hf, err_hw, st_iss, st_done, rd_req, rd_sel;
	logic [3:0] dev_state, acc_state;
	logic [55:0] err_regs;
	logic [15:0] hours;
	logic [7:0] st_sec, st_stat, st_cp, s_latch;
	logic [31:0] st_lba;
	logic rd_busy, rd_valid, rd_last;
	logic [7:0] rd_data;
	int err_count = 0;
	int num_checks = 0;
	// reference model of both logs
	logic [55:0] e_regs [5];
	logic [7:0] e_state [5];
	logic [15:0] e_hrs [5];
	logic [7:0] s_sec [21], s_stat [21], s_cp [21];
	logic [15:0] s_hrs [21];
	logic [31:0] s_lba [21];
	int e_idx = 0, e_cnt = 0, s_idx = 0;
	logic [7:0] exp_b [512];

	dlsb_log_builder dut_u (.CORE_CLK_IN(clk), .RESETN_IN(rstn), .CMD_ACCEPT_IN(cmd_acc),
		.DEV_STATE_IN(dev_state), .ERR_EVENT_IN(err_ev), .ERR_HOST_FAULT_IN(err_hf),
		.ERR_HW_RESET_IN(err_hw), .ERR_REGS_IN(err_regs), .LIFE_HOURS_IN(hours),
		.ST_ISSUE_IN(st_iss), .ST_SECTOR_IN(st_sec), .ST_DONE_IN(st_done),
		.ST_STATUS_IN(st_stat), .ST_CHECKPOINT_IN(st_cp), .ST_FAIL_LBA_IN(st_lba),
		.RD_REQ_IN(rd_req), .RD_SEL_IN(rd_sel), .RD_BUSY_OUT(rd_busy),
		.RD_VALID_OUT(rd_valid), .RD_DATA_OUT(rd_data), .RD_LAST_OUT(rd_last));
	dlsb_host_reader host_u (.clk_in(clk), .busy_in(rd_busy), .valid_in(rd_valid),
		.data_in(rd_data), .last_in(rd_last), .req_out(rd_req), .sel_out(rd_sel));

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// watchdog: the saturation burst dominates, about 69k cycles; limit at 90k
	initial
	begin
		#900000;
		err_count++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		end_sim();
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic ok, input string what);
		num_checks++;
		if (ok !== 1'b1)
		begin
			err_count++;
			$display("CHECK FAILED at %0t: %s", $time, what);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d, mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// fixed one-edge pulse per event; the accepted code stays on dev_state while idle
	task automatic accept(input logic [3:0] code);
		@(negedge clk);
		cmd_acc = 1'b1;
		dev_state = code;
		acc_state = code;
		@(negedge clk);
		cmd_acc = 1'b0;
	endtask
	// event held n edges: each edge is a separate error, logged unless it is a host fault
	task automatic err_burst(input logic hf, input logic hw, input int n);
		@(negedge clk);
		err_regs[31:0] = $urandom;
		err_regs[55:32] = 24'($urandom);
		hours = 16'($urandom);
		dev_state = 4'($urandom_range(0, 4));
		err_ev = 1'b1;
		err_hf = hf;
		err_hw = hw;
		repeat (n)
		begin
			if (!hf)
			begin
				e_idx = e_idx % 5 + 1;
				e_regs[e_idx-1] = hw ? {7{HWRST_VENDOR_BYTE}} : err_regs;
				e_state[e_idx-1] = {STATE_VENDOR_NIBBLE, hw ? dev_state : acc_state};
				e_hrs[e_idx-1] = hours;
				if (!hw && e_cnt < 65535)
					e_cnt++;
			end
			@(negedge clk);
		end
		err_ev = 1'b0;
		err_hf = 1'($urandom);
		err_hw = 1'($urandom);
	endtask
	// done takes the sector latched by an earlier issue, even when both coincide
	task automatic st_step(input logic iss, input logic dn);
		@(negedge clk);
		st_iss = iss;
		st_done = dn;
		st_sec = 8'($urandom);
		st_stat = 8'($urandom);
		st_cp = 8'($urandom);
		st_lba = $urandom;
		hours = 16'($urandom);
		if (dn)
		begin
			s_idx = s_idx % 21 + 1;
			s_sec[s_idx-1] = s_latch;
			s_stat[s_idx-1] = st_stat;
			s_cp[s_idx-1] = st_cp;
			s_hrs[s_idx-1] = hours;
			s_lba[s_idx-1] = st_lba;
		end
		if (iss)
			s_latch = st_sec;
		@(negedge clk);
		st_iss = 1'b0;
		st_done = 1'b0;
	endtask
	task automatic build_exp(input logic sel);
		int p;
		logic [7:0] s;
		s = 8'h00;
		for (p = 0; p < 512; p++)
			exp_b[p] = 8'h00;
		if (!sel)
		begin
			exp_b[0] = ERR_LOG_VERSION;
			exp_b[1] = e_idx[7:0];
			for (int k = 0; k < 5; k++)
			begin
				p = 2 + 90 * k;
				for (int j = 0; j < 7; j++)
					exp_b[p+61+j] = e_regs[k][8*j+:8];
				exp_b[p+87] = e_state[k];
				exp_b[p+88] = e_hrs[k][7:0];
				exp_b[p+89] = e_hrs[k][15:8];
			end
			exp_b[452] = e_cnt[7:0];
			exp_b[453] = e_cnt[15:8];
		end
		else
		begin
			exp_b[0] = ST_REVISION[7:0];
			exp_b[1] = ST_REVISION[15:8];
			for (int k = 0; k < 21; k++)
			begin
				p = 2 + 24 * k;
				{exp_b[p+1], exp_b[p]} = {s_stat[k], s_sec[k]};
				{exp_b[p+4], exp_b[p+3], exp_b[p+2]} = {s_cp[k], s_hrs[k]};
				{exp_b[p+8], exp_b[p+7], exp_b[p+6], exp_b[p+5]} = s_lba[k];
			end
			exp_b[508] = s_idx[7:0];
		end
		for (p = 0; p < 511; p++)
			s = s + exp_b[p];
		exp_b[511] = -s;
	endtask
	// a full sector is compared byte by byte against the model
	task automatic read_check(input logic sel);
		host_u.read_sector(sel);
		build_exp(sel);
		chk(host_u.got_n == 512, "byte count wrong or busy request taken");
		chk(host_u.last_pos == 511, "last flag not on byte 511");
		chk(rd_valid === 1'b0 && rd_busy === 1'b0, "stream not idle");
		for (int p = 0; p < 512; p++)
			chk(host_u.got[p] === exp_b[p], $sformatf("byte %0d sel %0b", p, sel));
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		{cmd_acc, err_ev, err_hf, err_hw, st_iss, st_done} = 6'h00;
		{dev_state, acc_state, err_regs, hours} = '0;
		{st_sec, st_stat, st_cp, st_lba, s_latch} = '0;
		for (int k = 0; k < 21; k++)
			{s_sec[k], s_stat[k], s_cp[k], s_hrs[k], s_lba[k]} = '0;
		for (int k = 0; k < 5; k++)
			{e_regs[k], e_state[k], e_hrs[k]} = '0;
		void'($urandom(32'hb896));
		rstn = 1'b0;
		repeat (12) @(negedge clk);
		rstn = 1'b1;
		// empty logs after reset
		read_check(1'b0);
		read_check(1'b1);
		// every state code, a host fault, a hardware reset, then wrap
		for (int c = 0; c < 5; c++)
		begin
			accept(4'(c));
			err_burst(1'b0, 1'b0, 1);
		end
		err_burst(1'b1, 1'b0, 1);
		err_burst(1'b0, 1'b1, 1);
		accept(STATE_ACTIVE);
		err_burst(1'b0, 1'b0, 2);
		read_check(1'b0);
		// self-test log: first entry, then wrap with coinciding issue and done
		st_step(1'b1, 1'b0);
		st_step(1'b0, 1'b1);
		read_check(1'b1);
		st_step(1'b1, 1'b0);
		for (int i = 0; i < 22; i++)
			st_step(1'b1, 1'b1);
		read_check(1'b1);
		// back-to-back errors well past the 16-bit count
		err_burst(1'b0, 1'b0, 65540);
		err_burst(1'b0, 1'b0, 1);
		read_check(1'b0);
		end_sim();
	end
endmodule
